//--- src/psq_pkg.sv
// Purpose: Shared constants and types of the power state sequencer
// Assumes: 125 MHz system clock, APB register access
// Notes:   Long delays are turned into cycle counts in this package
package psq_pkg;

   // Clock and timing figures
   localparam int CLK_MHZ      = 125;
   localparam int POR_SHORT_MS = 100;
   localparam int POR_LONG_MS  = 1000;
   localparam int DEBOUNCE_MS  = 56;
   localparam int PROC_RST_US  = 1000;
   localparam int RAMP_STEP_US = 100;
   localparam int POR_SHORT_CYC = POR_SHORT_MS * 1000 * CLK_MHZ;
   localparam int POR_LONG_CYC  = POR_LONG_MS * 1000 * CLK_MHZ;
   localparam int DEBOUNCE_CYC  = DEBOUNCE_MS * 1000 * CLK_MHZ;
   localparam int PROC_RST_CYC  = PROC_RST_US * CLK_MHZ;
   localparam int RAMP_STEP_CYC = RAMP_STEP_US * CLK_MHZ;
   localparam int CNT_W         = 27;

   // APB register map (byte offsets)
   localparam int         APB_AW        = 8;
   localparam logic [7:0] OFF_CTRL      = 8'h00;
   localparam logic [7:0] OFF_CONV_TWO  = 8'h04;
   localparam logic [7:0] OFF_LDO_CTRL  = 8'h08;
   localparam logic [7:0] OFF_CHG_CFG   = 8'h0C;
   localparam logic [7:0] OFF_STATUS    = 8'h10;

   // Field positions
   localparam int CTRL_SUPPLY_EN = 0;
   localparam int CTRL_SLEEP_ARM = 1;
   localparam int CONV_CORE_OFF  = 0;
   localparam int CONV_LVL_LSB   = 1;
   localparam int LDO_EN_LSB     = 0;
   localparam int LDO_OFF_LSB    = 2;
   localparam int CHG_AUTO_WAKE  = 7;

   // Reset values of software fields
   localparam logic       RST_SUPPLY_EN = 1'h1;
   localparam logic [1:0] RST_LDO_EN    = 2'h3;

   // Debounced input indices
   localparam int DB_WARM  = 0;
   localparam int DB_PBTN  = 1;
   localparam int DB_COVER = 2;

   // Power states, Gray coded along the power-up path
   typedef enum logic [2:0] {
      ST_NOPWR = 3'h0,
      ST_WAIT  = 3'h1,
      ST_RAMP  = 3'h3,
      ST_POR   = 3'h2,
      ST_ON    = 3'h6,
      ST_LP    = 3'h7,
      ST_DOWN  = 3'h5
   } psq_state_t;

   // Rail control bundle driven to the analog converters
   typedef struct packed {
      logic       main_en;
      logic       core_en;
      logic       core_sleep;
      logic [1:0] sleep_core_level;
      logic [1:0] ldo_en;
      logic [1:0] ldo_low_power;
      logic       reference_en;
   } psq_rails_t;

   // Software-visible control fields
   typedef struct packed {
      logic       supply_en;
      logic       sleep_arm_bit;
      logic       sleep_core_off;
      logic [1:0] sleep_core_level;
      logic [1:0] ldo_en;
      logic [1:0] ldo_off_or_sleep;
      logic       auto_wake_inhibit;
   } psq_regs_t;

endpackage

//--- src/psq_sequencer.sv
// Purpose: Power state sequencer with reset generation and APB registers
// Assumes: All pins synchronous to sys_clk_in except the sleep request pin
// Notes:   Open-drain outputs are plain active-low levels here
//
// Operation
// - Warm reset press pulses processor reset low
// - Processor reset also exits low-power mode
// - Power-fail low on lockout, overtemperature, cover low
// - Strap picks 100 ms or 1 s delay
// - First power: reference on, outputs held low
// - Cover high and supply ok ramps rails
// - Outputs released after timer, then on state
// - Below lockout, wait and auto-start later
// - On state exits on faults or sleep
// - Arm bit then pin; AND rising edge
// - Low-power core rail off or lowered
// - Per-LDO off or reduced power in sleep
// - Registers stay accessible in low-power mode
// - Low-power exits on faults, pin, buttons
// - Power application enters wait state first
// - Supply enable cleared plus sleep shuts down
// - Shutdown waits for buttons then powers up
// - Both LDO off bits give full shutdown
// - Auto-wake inhibit bit blocks charger wakeup
// - All off in wait resets registers
// - Reset follows main rail good plus delay
// - Buttons and cover debounced, 56 ms
// - Warm reset keeps settings, waits core good
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module psq_sequencer
   import psq_pkg::*;
#(
   parameter int POR_SHORT_N = POR_SHORT_CYC,
   parameter int POR_LONG_N  = POR_LONG_CYC,
   parameter int DEBOUNCE_N  = DEBOUNCE_CYC,
   parameter int PROC_RST_N  = PROC_RST_CYC,
   parameter int RAMP_STEP_N = RAMP_STEP_CYC
) (
   // Clock and reset
   input  wire logic              sys_clk_in,
   input  wire logic              reset_in,
   // APB slave
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [APB_AW-1:0] paddr_in,
   input  wire logic [31:0]       pwdata_in,
   output logic                   pready_out,
   output logic                   pslverr_out,
   output logic [31:0]            prdata_out,
   // Supply and fault monitors
   input  wire logic              supply_ok_in,
   input  wire logic              overtemp_in,
   input  wire logic              main_rail_good_in,
   input  wire logic              core_rail_good_in,
   input  wire logic              charge_voltage_ok_in,
   // Buttons, cover, straps and processor pin
   input  wire logic              warm_reset_button_n_in,
   input  wire logic              power_button_in,
   input  wire logic              battery_cover_in,
   input  wire logic              reset_delay_select_in,
   input  wire logic              rail_order_select_in,
   input  wire logic              sleep_request_pin_in,
   // Reset and warning outputs
   output logic                   power_on_reset_n_out,
   output logic                   power_fail_n_out,
   output logic                   int_hold_n_out,
   output logic                   proc_reset_n_out,
   // Rail controls
   output psq_rails_t             rails_out
);

   localparam logic [CNT_W-1:0] POR_SHORT_C = CNT_W'(POR_SHORT_N - 1);
   localparam logic [CNT_W-1:0] POR_LONG_C  = CNT_W'(POR_LONG_N - 1);
   localparam logic [CNT_W-1:0] DEB_C       = CNT_W'(DEBOUNCE_N - 1);
   localparam logic [CNT_W-1:0] PRST_C      = CNT_W'(PROC_RST_N);
   localparam logic [CNT_W-1:0] RAMP_C      = CNT_W'(RAMP_STEP_N - 1);

   // Whole module state
   typedef struct packed {
      psq_state_t           st;
      logic [1:0]           sreq_sync;
      logic                 sleep_and_d;
      logic [2:0]           db;
      logic [2:0]           db_prev;
      logic [2:0][CNT_W-1:0] db_cnt;
      logic [CNT_W-1:0]     tmr;
      logic [1:0]           step;
      logic                 strap;
      logic                 first_pwr;
      logic                 full_off;
      logic                 rst_pend;
      logic [CNT_W-1:0]     rst_cnt;
      psq_regs_t            regs;
      logic                 por_n;
      logic                 pfail_n;
      logic                 int_n;
      logic                 proc_rst_n;
      psq_rails_t           rails;
      logic                 pready;
      logic                 pslverr;
      logic [31:0]          prdata;
   } psq_state_s_t;

   psq_state_s_t q_r;
   psq_state_s_t q_nxt;

   // Register index from byte address; 3'h7 marks an unmapped word
   function automatic logic [2:0] reg_idx(input logic [APB_AW-1:0] a);
      logic [2:0] idx;
      idx = 3'h7;
      if (a == OFF_CTRL) begin
         idx = 3'h0;
      end else if (a == OFF_CONV_TWO) begin
         idx = 3'h1;
      end else if (a == OFF_LDO_CTRL) begin
         idx = 3'h2;
      end else if (a == OFF_CHG_CFG) begin
         idx = 3'h3;
      end else if (a == OFF_STATUS) begin
         idx = 3'h4;
      end
      return idx;
   endfunction

   // Next-state logic
   always_comb begin
      logic [2:0] raw;
      logic [2:0] press;
      logic       fault;
      logic       sleep_and;
      logic       sleep_rise;
      logic       first_rail_main;
      logic [2:0] idx;
      logic       wr;
      logic [CNT_W-1:0] por_c;
      raw = 3'h0;
      press = 3'h0;
      fault = 1'h0;
      sleep_and = 1'h0;
      sleep_rise = 1'h0;
      first_rail_main = 1'h0;
      idx = 3'h7;
      wr = 1'h0;
      por_c = POR_SHORT_C;
      q_nxt = q_r;

      // Sleep pin: first flop only feeds the second
      q_nxt.sreq_sync = {q_r.sreq_sync[0], sleep_request_pin_in};
      sleep_and = q_r.sreq_sync[1] & q_r.regs.sleep_arm_bit;
      q_nxt.sleep_and_d = sleep_and;
      sleep_rise = sleep_and & ~q_r.sleep_and_d;

      // Debounce: level must hold a full window before it is taken
      raw[DB_WARM] = ~warm_reset_button_n_in;
      raw[DB_PBTN] = power_button_in;
      raw[DB_COVER] = battery_cover_in;
      for (int i = 0; i < 3; i++) begin
         if (raw[i] == q_r.db[i]) begin
            q_nxt.db_cnt[i] = '0;
         end else if (q_r.db_cnt[i] == DEB_C) begin
            q_nxt.db[i] = raw[i];
            q_nxt.db_cnt[i] = '0;
         end else begin
            q_nxt.db_cnt[i] = q_r.db_cnt[i] + 1'b1;
         end
      end
      q_nxt.db_prev = q_r.db;
      press = q_r.db & ~q_r.db_prev;

      // Fault conditions outrank every other transition out of ST_RAMP, ST_POR, ST_ON and ST_LP
      fault = ~supply_ok_in | overtemp_in | ~q_r.db[DB_COVER];
      first_rail_main = ~rail_order_select_in;
      por_c = q_r.strap ? POR_LONG_C : POR_SHORT_C;

      // APB: registers answer in every power state
      idx = reg_idx(paddr_in);
      wr = psel_in & penable_in & q_r.pready & pwrite_in;
      if (wr) begin
         unique case (idx)
            3'h0: begin
               q_nxt.regs.supply_en = pwdata_in[CTRL_SUPPLY_EN];
               q_nxt.regs.sleep_arm_bit = pwdata_in[CTRL_SLEEP_ARM];
            end
            3'h1: begin
               q_nxt.regs.sleep_core_off = pwdata_in[CONV_CORE_OFF];
               q_nxt.regs.sleep_core_level = pwdata_in[CONV_LVL_LSB +: 2];
            end
            3'h2: begin
               q_nxt.regs.ldo_en = pwdata_in[LDO_EN_LSB +: 2];
               q_nxt.regs.ldo_off_or_sleep = pwdata_in[LDO_OFF_LSB +: 2];
            end
            3'h3: q_nxt.regs.auto_wake_inhibit = pwdata_in[CHG_AUTO_WAKE];
            default: ;
         endcase
      end
      q_nxt.pready = psel_in & ~penable_in;
      q_nxt.pslverr = psel_in & ~penable_in & (idx == 3'h7);
      q_nxt.prdata = 32'h0;
      if (psel_in & ~penable_in) begin
         unique case (idx)
            3'h0: q_nxt.prdata = {30'h0, q_r.regs.sleep_arm_bit, q_r.regs.supply_en};
            3'h1: q_nxt.prdata = {29'h0, q_r.regs.sleep_core_level, q_r.regs.sleep_core_off};
            3'h2: q_nxt.prdata = {28'h0, q_r.regs.ldo_off_or_sleep, q_r.regs.ldo_en};
            3'h3: q_nxt.prdata = {24'h0, q_r.regs.auto_wake_inhibit, 7'h0};
            3'h4: q_nxt.prdata = {23'h0, q_r.rst_pend, q_r.full_off, q_r.strap,
                                 q_r.db, q_r.st};
            default: q_nxt.prdata = 32'h0;
         endcase
      end

      // Warm reset press: reset request, settings untouched
      if (press[DB_WARM] && (q_r.st == ST_ON || q_r.st == ST_LP)) begin
         q_nxt.rst_pend = 1'h1;
      end

      // Power state machine
      unique case (q_r.st)
         ST_NOPWR: begin
            q_nxt.strap = reset_delay_select_in;
            q_nxt.st = ST_WAIT;
         end
         ST_WAIT: begin
            // Wake on first power, buttons, or charger unless inhibited
            if (supply_ok_in && q_r.db[DB_COVER] &&
                (q_r.first_pwr || press[DB_PBTN] || press[DB_WARM] ||
                 (~q_r.regs.auto_wake_inhibit && charge_voltage_ok_in))) begin
               if (q_r.full_off) begin
                  q_nxt.regs = '0;
                  q_nxt.regs.supply_en = RST_SUPPLY_EN;
                  q_nxt.regs.ldo_en = RST_LDO_EN;
               end
               q_nxt.full_off = 1'h0;
               q_nxt.st = ST_RAMP;
               q_nxt.step = 2'h0;
               q_nxt.tmr = '0;
            end
         end
         ST_RAMP: begin
            if (fault) begin
               q_nxt.st = ST_DOWN;
               q_nxt.step = 2'h0;
               q_nxt.tmr = '0;
            end else if (q_r.step != 2'h2) begin
               // Rails follow the order strap, one step apart
               if (q_r.tmr == RAMP_C) begin
                  q_nxt.step = q_r.step + 2'h1;
                  q_nxt.tmr = '0;
               end else begin
                  q_nxt.tmr = q_r.tmr + 1'b1;
               end
            end else if (main_rail_good_in) begin
               q_nxt.st = ST_POR;
               q_nxt.tmr = '0;
            end
         end
         ST_POR: begin
            if (fault) begin
               q_nxt.st = ST_DOWN;
               q_nxt.step = 2'h0;
               q_nxt.tmr = '0;
            end else if (!main_rail_good_in) begin
               q_nxt.tmr = '0;
            end else if (q_r.tmr == por_c) begin
               q_nxt.st = ST_ON;
               q_nxt.first_pwr = 1'h0;
            end else begin
               q_nxt.tmr = q_r.tmr + 1'b1;
            end
         end
         ST_ON: begin
            if (fault) begin
               q_nxt.st = ST_DOWN;
               q_nxt.step = 2'h0;
               q_nxt.tmr = '0;
            end else if (sleep_rise) begin
               if (q_r.regs.supply_en) begin
                  q_nxt.st = ST_LP;
               end else begin
                  q_nxt.st = ST_DOWN;
                  q_nxt.step = 2'h0;
                  q_nxt.tmr = '0;
                  q_nxt.full_off = &q_r.regs.ldo_off_or_sleep;
               end
            end
         end
         ST_LP: begin
            if (fault) begin
               q_nxt.st = ST_DOWN;
               q_nxt.step = 2'h0;
               q_nxt.tmr = '0;
            end else if (!q_r.sreq_sync[1] || press[DB_PBTN] || press[DB_WARM]) begin
               q_nxt.st = ST_ON;
            end
         end
         ST_DOWN: begin
            // Reverse order ramp-down, then everything waits
            if (q_r.tmr == RAMP_C) begin
               q_nxt.tmr = '0;
               if (q_r.step == 2'h1) begin
                  q_nxt.st = ST_WAIT;
               end else begin
                  q_nxt.step = q_r.step + 2'h1;
               end
            end else begin
               q_nxt.tmr = q_r.tmr + 1'b1;
            end
            q_nxt.rst_pend = 1'h0;
         end
         default: q_nxt.st = ST_NOPWR;
      endcase

      // Processor reset pulse only once core rail regulates
      if (q_r.rst_cnt != '0) begin
         q_nxt.rst_cnt = q_r.rst_cnt - 1'b1;
      end else if (q_r.rst_pend && core_rail_good_in && q_nxt.st == ST_ON) begin
         q_nxt.rst_cnt = PRST_C;
         q_nxt.rst_pend = 1'h0;
      end

      // Rail enables from the coming state
      q_nxt.rails = '0;
      q_nxt.rails.reference_en = 1'h1;
      q_nxt.rails.sleep_core_level = q_nxt.regs.sleep_core_level;
      unique case (q_nxt.st)
         ST_RAMP: begin
            q_nxt.rails.main_en = first_rail_main | (q_nxt.step != 2'h0);
            q_nxt.rails.core_en = ~first_rail_main | (q_nxt.step != 2'h0);
            q_nxt.rails.ldo_en = (q_nxt.step == 2'h2) ? q_nxt.regs.ldo_en : 2'h0;
         end
         ST_POR, ST_ON: begin
            q_nxt.rails.main_en = 1'h1;
            q_nxt.rails.core_en = 1'h1;
            q_nxt.rails.ldo_en = q_nxt.regs.ldo_en;
         end
         ST_LP: begin
            q_nxt.rails.main_en = 1'h1;
            q_nxt.rails.core_en = ~q_nxt.regs.sleep_core_off;
            q_nxt.rails.core_sleep = ~q_nxt.regs.sleep_core_off;
            q_nxt.rails.ldo_en = q_nxt.regs.ldo_en & ~q_nxt.regs.ldo_off_or_sleep;
            q_nxt.rails.ldo_low_power = q_nxt.rails.ldo_en;
         end
         ST_DOWN: begin
            q_nxt.rails.main_en = (q_nxt.step == 2'h0) | first_rail_main;
            q_nxt.rails.core_en = (q_nxt.step == 2'h0) | ~first_rail_main;
            q_nxt.rails.ldo_en = q_nxt.regs.ldo_en & ~q_nxt.regs.ldo_off_or_sleep;
         end
         ST_WAIT: begin
            q_nxt.rails.ldo_en = q_nxt.regs.ldo_en & ~q_nxt.regs.ldo_off_or_sleep;
            q_nxt.rails.ldo_low_power = q_nxt.rails.ldo_en;
            q_nxt.rails.reference_en = (|q_nxt.rails.ldo_en) | ~supply_ok_in;
         end
         default: ;
      endcase

      // Output levels; power-on reset gates the others
      q_nxt.por_n = (q_nxt.st == ST_ON) || (q_nxt.st == ST_LP);
      q_nxt.pfail_n = q_nxt.por_n & supply_ok_in & ~overtemp_in & q_r.db[DB_COVER];
      q_nxt.int_n = q_nxt.por_n;
      q_nxt.proc_rst_n = q_nxt.por_n & (q_nxt.rst_cnt == '0);

      // Synchronous reset: power application
      if (reset_in) begin
         q_nxt = '0;
         q_nxt.st = ST_NOPWR;
         q_nxt.first_pwr = 1'h1;
         q_nxt.regs.supply_en = RST_SUPPLY_EN;
         q_nxt.regs.ldo_en = RST_LDO_EN;
         q_nxt.rails.reference_en = 1'h1;
      end
   end

   // Single state register
   always_ff @(posedge sys_clk_in) begin
      q_r <= q_nxt;
   end

   // Outputs straight from flops
   assign pready_out           = q_r.pready;
   assign pslverr_out          = q_r.pslverr;
   assign prdata_out           = q_r.prdata;
   assign power_on_reset_n_out = q_r.por_n;
   assign power_fail_n_out     = q_r.pfail_n;
   assign int_hold_n_out       = q_r.int_n;
   assign proc_reset_n_out     = q_r.proc_rst_n;
   assign rails_out            = q_r.rails;

endmodule

`default_nettype wire

//--- bench/psq_sequencer_props.sv
// Purpose: Port assertions of the power state sequencer
// Assumes: Bound to psq_sequencer, one clock domain
// Notes:   Count parameters are handed on by the bind
`timescale 1ns/1ps
`default_nettype none
module psq_sequencer_props
   import psq_pkg::*;
#(
   parameter int POR_SHORT_N = 20,
   parameter int PROC_RST_N  = 4
) (
   input wire logic        sys_clk_in,
   input wire logic        reset_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   input wire logic [31:0] prdata_out,
   input wire logic        supply_ok_in,
   input wire logic        overtemp_in,
   input wire logic        main_rail_good_in,
   input wire logic        rail_order_select_in,
   input wire logic        power_on_reset_n_out,
   input wire logic        power_fail_n_out,
   input wire logic        int_hold_n_out,
   input wire logic        proc_reset_n_out,
   input wire psq_rails_t  rails_out
);
   int good_cnt_r;
   int low_cnt_r;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   // Run lengths; good rail and a reset pulse with the outputs released
   always_ff @(posedge sys_clk_in) begin
      good_cnt_r <= main_rail_good_in ? good_cnt_r + 1 : 0;
      low_cnt_r  <= (!proc_reset_n_out && power_on_reset_n_out) ? low_cnt_r + 1 : 0;
   end
   // Setup phase of a bus transfer
   sequence s_setup;
      psel_in && !penable_in;
   endsequence
   // A fault while the outputs are released
   sequence s_fault;
      power_on_reset_n_out && (!supply_ok_in || overtemp_in);
   endsequence
   AST_READY_AFTER_SETUP: assert property (s_setup |=> pready_out)
      else $error("no ready after setup");
   AST_READY_ONLY_ACCESS: assert property (pready_out |-> $past(psel_in && !penable_in))
      else $error("ready without setup");
   AST_IDLE_DATA_ZERO: assert property (!pready_out |-> prdata_out == 32'h0 && !pslverr_out)
      else $error("bus outputs active while idle");
   AST_POR_HOLDS_OUTPUTS: assert property (!power_on_reset_n_out |-> !proc_reset_n_out && !power_fail_n_out && !int_hold_n_out)
      else $error("output released while power-on reset low");
   AST_FAIL_ON_FAULT: assert property (power_fail_n_out |-> $past(supply_ok_in) && !$past(overtemp_in))
      else $error("power fail high during fault");
   AST_FAULT_EXIT: assert property (s_fault |-> ##[1:3] !power_on_reset_n_out)
      else $error("no exit on fault");
   AST_POR_DELAY: assert property ($rose(power_on_reset_n_out) |-> good_cnt_r >= POR_SHORT_N)
      else $error("reset released too early");
   AST_PULSE_LENGTH: assert property ($rose(proc_reset_n_out) && $past(power_on_reset_n_out) |-> low_cnt_r == PROC_RST_N)
      else $error("processor reset pulse length wrong");
   AST_RAIL_ORDER: assert property (($rose(rails_out.core_en) && !rail_order_select_in) || ($rose(rails_out.main_en) && rail_order_select_in) |-> rails_out.main_en && rails_out.core_en)
      else $error("rails ramped out of order");
   AST_MAIN_STAYS: assert property (power_on_reset_n_out |-> rails_out.main_en)
      else $error("main rail off while released");
endmodule
bind psq_sequencer psq_sequencer_props #(.POR_SHORT_N(POR_SHORT_N), .PROC_RST_N(PROC_RST_N)) u_props (
   .sys_clk_in, .reset_in, .psel_in, .penable_in, .pready_out, .pslverr_out, .prdata_out, .supply_ok_in,
   .overtemp_in, .main_rail_good_in, .rail_order_select_in, .power_on_reset_n_out, .power_fail_n_out,
   .int_hold_n_out, .proc_reset_n_out, .rails_out);
`default_nettype wire

//--- bench/psq_far_side.sv
// Purpose: Rails and buttons beside the sequencer
// Assumes: Press commands are one-cycle pulses from the bench
// Notes:   Slow mode delays rail good to stretch the ramp
`timescale 1ns/1ps
`default_nettype none
module psq_far_side
   import psq_pkg::*;
(
   // Clock, reset and bench commands
   input  wire logic       sys_clk_in,
   input  wire logic       reset_in,
   input  wire logic       press_warm_in,
   input  wire logic       press_power_in,
   input  wire logic       slow_in,
   // Rail enables from the device
   input  wire psq_rails_t rails_in,
   // Device inputs
   output logic            main_rail_good_out,
   output logic            core_rail_good_out,
   output logic            warm_reset_button_n_out,
   output logic            power_button_out
);
   logic [3:0] main_dly_r;
   logic [3:0] core_dly_r;
   int         warm_cnt_r;
   int         pwr_cnt_r;
   // Good follows enable; presses outlast the debounce time
   always_ff @(posedge sys_clk_in) begin
      main_dly_r <= reset_in ? 4'h0 : {main_dly_r[2:0], rails_in.main_en};
      core_dly_r <= reset_in ? 4'h0 : {core_dly_r[2:0], rails_in.core_en};
      warm_cnt_r <= reset_in ? 0 : press_warm_in ? 8 : (warm_cnt_r > 0 ? warm_cnt_r - 1 : 0);
      pwr_cnt_r  <= reset_in ? 0 : press_power_in ? 8 : (pwr_cnt_r > 0 ? pwr_cnt_r - 1 : 0);
   end
   assign main_rail_good_out      = slow_in ? &main_dly_r : main_dly_r[0];
   assign core_rail_good_out      = slow_in ? &core_dly_r : core_dly_r[0];
   // Idle levels follow the pull-up and pull-down
   assign warm_reset_button_n_out = !(warm_cnt_r > 0);
   assign power_button_out        = pwr_cnt_r > 0;
endmodule
`default_nettype wire

//--- bench/test_psq_sequencer.sv
// Purpose: Self-checking bench of the power state sequencer
// Assumes: Short counts so a full power cycle fits the run
// Notes:   Register reads of the state field track the sequence
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
   $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module test_psq_sequencer;
   import psq_pkg::*;
   localparam int PROC_N = 4;
   logic        sys_clk_in, reset_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
   logic [7:0]  paddr_in;
   logic [31:0] pwdata_in, prdata_out, q, d;
   logic        supply_ok_in, overtemp_in, main_rail_good_in, core_rail_good_in, charge_voltage_ok_in;
   logic        warm_reset_button_n_in, power_button_in, battery_cover_in, reset_delay_select_in;
   logic        rail_order_select_in, sleep_request_pin_in, power_on_reset_n_out, power_fail_n_out;
   logic        int_hold_n_out, proc_reset_n_out, e, pw, pp, slow;
   psq_rails_t  rails_out;
   int          n_fail, comparisons, seed, k;
   psq_sequencer #(.POR_SHORT_N(20), .POR_LONG_N(40), .DEBOUNCE_N(5), .PROC_RST_N(PROC_N),
      .RAMP_STEP_N(3)) u_psq_sequencer (.sys_clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in,
      .paddr_in, .pwdata_in, .pready_out, .pslverr_out, .prdata_out, .supply_ok_in, .overtemp_in,
      .main_rail_good_in, .core_rail_good_in, .charge_voltage_ok_in, .warm_reset_button_n_in,
      .power_button_in, .battery_cover_in, .reset_delay_select_in, .rail_order_select_in,
      .sleep_request_pin_in, .power_on_reset_n_out, .power_fail_n_out, .int_hold_n_out,
      .proc_reset_n_out, .rails_out);
   psq_far_side u_psq_far_side (.sys_clk_in, .reset_in, .press_warm_in(pw), .press_power_in(pp),
      .slow_in(slow), .rails_in(rails_out), .main_rail_good_out(main_rail_good_in),
      .core_rail_good_out(core_rail_good_in), .warm_reset_button_n_out(warm_reset_button_n_in),
      .power_button_out(power_button_in));
   // Free-running 125 MHz clock
   always #4 sys_clk_in = !sys_clk_in;
   // One bus transfer, held until ready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge sys_clk_in);
      psel_in <= 1'b1; penable_in <= 1'b0; pwrite_in <= w; paddr_in <= a; pwdata_in <= wd;
      @(posedge sys_clk_in);
      penable_in <= 1'b1;
      do @(posedge sys_clk_in); while (pready_out !== 1'b1);
      q = prdata_out;
      e = pslverr_out;
      psel_in <= 1'b0; penable_in <= 1'b0;
   endtask
   // Poll the state field; bounded so a stuck sequencer fails
   task automatic wait_state(input logic [2:0] s);
      int n;
      n = 0;
      do begin apb(1'b0, OFF_STATUS, 32'h0); n++; end while (q[2:0] !== s && n < 300);
      `CHK(q[2:0], s)
   endtask
   // Button press pulse towards the far side
   task automatic press(input logic warm);
      @(posedge sys_clk_in);
      if (warm) pw <= 1'b1; else pp <= 1'b1;
      @(posedge sys_clk_in);
      pw <= 1'b0; pp <= 1'b0;
   endtask
   task automatic summarize();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (60000) @(posedge sys_clk_in);
      n_fail++;
      summarize();
   end
   // Main sequence
   initial begin
      seed = 32'h935C; n_fail = 0; comparisons = 0;
      sys_clk_in = 0; reset_in = 1; psel_in = 0; penable_in = 0; pwrite_in = 0; paddr_in = 8'h00;
      pwdata_in = 32'h0; supply_ok_in = 0; overtemp_in = 0; charge_voltage_ok_in = 0;
      battery_cover_in = 0; sleep_request_pin_in = 0; pw = 0; pp = 0; slow = 0;
      reset_delay_select_in = $random(seed); rail_order_select_in = $random(seed);
      repeat (12) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      apb(1'b0, OFF_CTRL, 32'h0); `CHK(q, 32'h1)
      apb(1'b0, OFF_LDO_CTRL, 32'h0); `CHK(q, 32'h3)
      apb(1'b0, 8'h14, 32'h0); `CHK({e, q}, 33'h100000000)
      apb(1'b1, OFF_STATUS, 32'hFFFFFFFF); wait_state(ST_WAIT);
      `CHK(q[6], reset_delay_select_in)
      for (int i = 0; i < 4; i++) begin
         d = $random(seed);
         apb(1'b1, OFF_CONV_TWO, d); apb(1'b0, OFF_CONV_TWO, 32'h0); `CHK(q, d & 32'h7)
         apb(1'b1, OFF_CHG_CFG, d); apb(1'b0, OFF_CHG_CFG, 32'h0); `CHK(q, d & 32'h80)
      end
      apb(1'b1, OFF_CHG_CFG, 32'h0);
      battery_cover_in <= 1'b1; supply_ok_in <= 1'b1; wait_state(ST_ON);
      `CHK({power_on_reset_n_out, power_fail_n_out, int_hold_n_out}, 3'h7)
      press(1'b1); k = 0;
      repeat (60) begin @(posedge sys_clk_in); if (proc_reset_n_out === 1'b0) k++; end
      `CHK(k, PROC_N)
      apb(1'b0, OFF_CTRL, 32'h0); `CHK(q, 32'h1)
      apb(1'b1, OFF_CONV_TWO, 32'h1); apb(1'b1, OFF_LDO_CTRL, 32'h7); apb(1'b1, OFF_CTRL, 32'h3);
      sleep_request_pin_in <= 1'b1; wait_state(ST_LP);
      `CHK({rails_out.main_en, rails_out.core_en, rails_out.ldo_en}, 4'hA)
      `CHK(rails_out.ldo_low_power[1], 1'b1)
      apb(1'b0, OFF_CONV_TWO, 32'h0); `CHK(q, 32'h1)
      sleep_request_pin_in <= 1'b0; wait_state(ST_ON);
      press(1'b1); apb(1'b1, OFF_CTRL, 32'h1); repeat (30) @(posedge sys_clk_in);
      sleep_request_pin_in <= 1'b1; repeat (12) @(posedge sys_clk_in); wait_state(ST_ON);
      sleep_request_pin_in <= 1'b0; apb(1'b1, OFF_CTRL, 32'h2); apb(1'b1, OFF_LDO_CTRL, 32'hF);
      sleep_request_pin_in <= 1'b1; wait_state(ST_WAIT);
      `CHK({rails_out.main_en, rails_out.core_en, rails_out.reference_en}, 3'h0)
      sleep_request_pin_in <= 1'b0; slow <= 1'b1; press(1'b0); wait_state(ST_ON);
      apb(1'b0, OFF_LDO_CTRL, 32'h0); `CHK(q, 32'h3)
      overtemp_in <= 1'b1; repeat (3) @(posedge sys_clk_in);
      `CHK(power_fail_n_out, 1'b0)
      wait_state(ST_WAIT);
      overtemp_in <= 1'b0; charge_voltage_ok_in <= 1'b1; wait_state(ST_ON);
      battery_cover_in <= 1'b0; repeat (8) @(posedge sys_clk_in);
      `CHK(power_fail_n_out, 1'b0)
      wait_state(ST_WAIT);
      summarize();
   end
endmodule
`default_nettype wire
